/* File: bsiu_top.sv */
// Boundary scan instruction unit top
// Notes on behaviour
// (RULE1) Instruction register: 3-bit shift stage plus 3-bit latched current instruction.
// (RULE2) In Shift-IR the shift stage sits between data in and out, shifting each rise.
// (RULE3) Rise with mode-select high in Exit1-IR or Exit2-IR enters Update-IR.
// (RULE4) Falling edge after entering Update-IR copies shift stage to current instruction.
// (RULE5) Codes: 000 extest, 001 idcode, 010 sample, 011 clamp, 100 highz, others bypass.
// (RULE6) Sample/preload samples pins without disturbing normal operation; preloads cells.
// (RULE7) Sample/preload puts boundary register in path; capture then shift out.
// (RULE8) Boundary instruction: rise in Capture-DR loads input pins into boundary register.
// (RULE9) Extest made current drives outputs from boundary values from the rising edge.
// (RULE10) Extest: falling edge in Update-DR drives outputs with shifted-in values.
// (RULE11) Other instruction than extest, clamp or highz returns outputs at Update-IR rise.
// (RULE12) Bypass: one-bit register joins data in to out; normal operation unaffected.
// (RULE13) Idcode selects identification word, loaded in Capture-DR, shifted in Shift-DR.
// (RULE14) Test-Logic-Reset forces idcode into the current instruction.
// (RULE15) Highz floats all outputs and places bypass in path.
// (RULE16) High impedance starts and ends at the Update-IR rising edge.
// (RULE17) Clamp drives outputs from boundary latches, unchanged, with bypass in path.
// (RULE18) Clamp after non-extest starts driving boundary values at Update-IR rise.
// (RULE19) Identification word: revision 31:28, device 27:12, maker 11:1, bit 0 one.
// (RULE20) During instruction shift the captured pattern shifts out with low bits 01.
// (RULE21) Asynchronous test reset returns controller to reset at any time.
// (RULE22) Under boundary instructions every functional pin acts as a bidirectional cell.
// (RULE23) Controller advances only on test clock rises, steered by mode-select.
// (RULE24) Five rises with mode-select high reach Test-Logic-Reset from any state.
// (RULE25) Capture-IR loads fixed value 001 into the shift stage.
// (RULE26) Data out changes on falling edges and floats outside the shift states.
`timescale 1ns/1ps
module bsiu_top #(
  parameter int N_PINS = 8,
  parameter logic [3:0] ID_REV = bsiu_pkg::ID_REV_DEF,
  parameter logic [15:0] ID_DEV = bsiu_pkg::ID_DEV_DEF,
  parameter logic [10:0] ID_MFR = bsiu_pkg::ID_MFR_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_test_clock_pin,
  input wire logic i_test_mode_select_pin,
  input wire logic i_test_data_in_pin,
  input wire logic i_test_reset_n_pin,
  input wire logic [N_PINS-1:0] i_func_out,
  input wire logic [N_PINS-1:0] i_func_oe,
  input wire logic [N_PINS-1:0] i_pad_in,
  output logic [N_PINS-1:0] o_pad_out,
  output logic [N_PINS-1:0] o_pad_oe,
  output logic o_test_data_out_pin,
  output logic o_test_data_out_oe,
  output logic [2:0] o_instr
);
  // ------------------------------------------------------------
  // Pin synchronisers and edges
  // ------------------------------------------------------------
  logic [1:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic [1:0] trst_sync;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic trst_n;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h3;
      trst_sync <= 2'h0;
      tck_prev <= 1'h0;
    end else begin
      tck_sync <= {tck_sync[0], i_test_clock_pin};
      tms_sync <= {tms_sync[0], i_test_mode_select_pin};
      tdi_sync <= {tdi_sync[0], i_test_data_in_pin};
      trst_sync <= {trst_sync[0], i_test_reset_n_pin};
      tck_prev <= tck_sync[1];
    end
  end
  assign tck_rise = tck_sync[1] & ~tck_prev;
  assign tck_fall = ~tck_sync[1] & tck_prev;
  assign trst_n = i_rstn & trst_sync[1]; // RULE21

  // ------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------
  bsiu_pkg::bsiu_tap_e state;
  bsiu_tap_fsm u_fsm ( // RULE23 RULE24 RULE3
    .i_sys_clk(i_sys_clk),
    .i_rstn(trst_n),
    .i_rise(tck_rise),
    .i_tms(tms_sync[1]),
    .o_state(state)
  );

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  logic [2:0] ir_shift;
  logic [2:0] ir_cur;
  logic upd_ir_pend;
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      ir_shift <= bsiu_pkg::IR_CAPTURE;
    end else if (tck_rise && state == bsiu_pkg::TAP_CAP_IR) begin
      ir_shift <= bsiu_pkg::IR_CAPTURE; // RULE25 RULE20
    end else if (tck_rise && state == bsiu_pkg::TAP_SHIFT_IR) begin
      ir_shift <= {tdi_sync[1], ir_shift[2:1]}; // RULE2
    end
  end
  // Current instruction, copied on falling edge in Update-IR
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      ir_cur <= bsiu_pkg::IR_IDCODE;
    end else if (state == bsiu_pkg::TAP_RESET) begin
      ir_cur <= bsiu_pkg::IR_IDCODE; // RULE14
    end else if (tck_fall && state == bsiu_pkg::TAP_UPD_IR && upd_ir_pend) begin
      ir_cur <= ir_shift; // RULE4 RULE1
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      upd_ir_pend <= 1'h0;
    end else if (tck_rise) begin
      upd_ir_pend <= (state == bsiu_pkg::TAP_EXIT1_IR || state == bsiu_pkg::TAP_EXIT2_IR)
                     && tms_sync[1];
    end else if (tck_fall) begin
      upd_ir_pend <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic sel_bsr;
  logic sel_id;
  logic is_extest;
  logic is_clamp;
  logic is_highz;
  assign sel_bsr = ir_cur == bsiu_pkg::IR_EXTEST || ir_cur == bsiu_pkg::IR_SAMPLE; // RULE5
  assign sel_id = ir_cur == bsiu_pkg::IR_IDCODE; // RULE5
  assign is_extest = ir_cur == bsiu_pkg::IR_EXTEST;
  assign is_clamp = ir_cur == bsiu_pkg::IR_CLAMP;
  assign is_highz = ir_cur == bsiu_pkg::IR_HIGHZ;

  // ------------------------------------------------------------
  // Data registers
  // ------------------------------------------------------------
  localparam int BSR_LEN = 2 * N_PINS;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_latch;
  logic [bsiu_pkg::ID_LEN-1:0] id_shift;
  logic bypass;
  logic [bsiu_pkg::ID_LEN-1:0] id_word;
  assign id_word = {ID_REV, ID_DEV, ID_MFR, bsiu_pkg::ID_LSB}; // RULE19
  // Each pin is one bidirectional cell: data bit and enable bit
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      bsr_shift <= '0;
    end else if (tck_rise && sel_bsr && state == bsiu_pkg::TAP_CAP_DR) begin
      bsr_shift <= {i_pad_in, i_func_oe}; // RULE8 RULE6 RULE22
    end else if (tck_rise && sel_bsr && state == bsiu_pkg::TAP_SHIFT_DR) begin
      bsr_shift <= {tdi_sync[1], bsr_shift[BSR_LEN-1:1]}; // RULE7
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      bsr_latch <= '0;
    end else if (tck_fall && sel_bsr && state == bsiu_pkg::TAP_UPD_DR) begin
      bsr_latch <= bsr_shift; // RULE10 RULE6
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      id_shift <= '0;
    end else if (tck_rise && sel_id && state == bsiu_pkg::TAP_CAP_DR) begin
      id_shift <= id_word; // RULE13
    end else if (tck_rise && sel_id && state == bsiu_pkg::TAP_SHIFT_DR) begin
      id_shift <= {tdi_sync[1], id_shift[bsiu_pkg::ID_LEN-1:1]}; // RULE13
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      bypass <= 1'h0;
    end else if (tck_rise && state == bsiu_pkg::TAP_CAP_DR) begin
      bypass <= 1'h0;
    end else if (tck_rise && state == bsiu_pkg::TAP_SHIFT_DR) begin
      bypass <= tdi_sync[1]; // RULE12 RULE15 RULE17
    end
  end

  // ------------------------------------------------------------
  // Output pin control
  // ------------------------------------------------------------
  logic mode_bsr;
  logic mode_hiz;
  logic at_upd_ir_rise;
  assign at_upd_ir_rise = tck_rise && state == bsiu_pkg::TAP_UPD_IR;
  // Mode changes only at the rising edge leaving Update-IR
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      mode_bsr <= 1'h0;
      mode_hiz <= 1'h0;
    end else if (at_upd_ir_rise) begin
      mode_bsr <= is_extest | is_clamp; // RULE9 RULE11 RULE18
      mode_hiz <= is_highz; // RULE16 RULE15
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
    end else if (mode_hiz) begin
      o_pad_out <= '0;
      o_pad_oe <= '0; // RULE15
    end else if (mode_bsr) begin
      o_pad_out <= bsr_latch[BSR_LEN-1:N_PINS]; // RULE9 RULE17
      o_pad_oe <= bsr_latch[N_PINS-1:0];
    end else begin
      o_pad_out <= i_func_out; // RULE12 RULE6
      o_pad_oe <= i_func_oe;
    end
  end

  // ------------------------------------------------------------
  // Test data out
  // ------------------------------------------------------------
  logic next_tdo;
  always_comb begin
    if (state == bsiu_pkg::TAP_SHIFT_IR) begin
      next_tdo = ir_shift[0];
    end else if (sel_bsr) begin
      next_tdo = bsr_shift[0];
    end else if (sel_id) begin
      next_tdo = id_shift[0];
    end else begin
      next_tdo = bypass;
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      o_test_data_out_pin <= 1'h0;
      o_test_data_out_oe <= 1'h0;
    end else if (tck_fall) begin
      o_test_data_out_pin <= next_tdo; // RULE26
      o_test_data_out_oe <= state == bsiu_pkg::TAP_SHIFT_IR
                            || state == bsiu_pkg::TAP_SHIFT_DR;
    end
  end
  always_ff @(posedge i_sys_clk or negedge trst_n) begin
    if (!trst_n) begin
      o_instr <= bsiu_pkg::IR_IDCODE;
    end else begin
      o_instr <= ir_cur;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_capir;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (tck_rise && state == bsiu_pkg::TAP_CAP_IR) |=> ir_shift == bsiu_pkg::IR_CAPTURE;
  endproperty
  a_capir: assert property (p_capir) else $error("capture-ir value wrong"); // RULE25
  property p_tlr;
    @(posedge i_sys_clk) disable iff (!trst_n)
    state == bsiu_pkg::TAP_RESET |=> ir_cur == bsiu_pkg::IR_IDCODE;
  endproperty
  a_tlr: assert property (p_tlr) else $error("reset state lacks idcode"); // RULE14
  property p_updir;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (tck_fall && state == bsiu_pkg::TAP_UPD_IR && upd_ir_pend) |=> ir_cur == $past(ir_shift);
  endproperty
  a_updir: assert property (p_updir) else $error("instruction not latched"); // RULE4
  property p_irhold;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (state == bsiu_pkg::TAP_SHIFT_IR) |=> $stable(ir_cur);
  endproperty
  a_irhold: assert property (p_irhold) else $error("instruction changed in shift"); // RULE1
  property p_irshift;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (tck_rise && state == bsiu_pkg::TAP_SHIFT_IR) |=> ir_shift[2] == $past(tdi_sync[1]);
  endproperty
  a_irshift: assert property (p_irshift) else $error("ir shift wrong"); // RULE2
  property p_idcap;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (tck_rise && sel_id && state == bsiu_pkg::TAP_CAP_DR) |=> id_shift[0] == 1'h1;
  endproperty
  a_idcap: assert property (p_idcap) else $error("id bit 0 not one"); // RULE19
  property p_hiz;
    @(posedge i_sys_clk) disable iff (!trst_n)
    mode_hiz |=> o_pad_oe == '0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not floated"); // RULE15
  property p_mode;
    @(posedge i_sys_clk) disable iff (!trst_n)
    at_upd_ir_rise |=> mode_bsr == (is_extest | is_clamp) && mode_hiz == is_highz;
  endproperty
  a_mode: assert property (p_mode) else $error("pin mode not updated"); // RULE11
  property p_tdoz;
    @(posedge i_sys_clk) disable iff (!trst_n)
    (tck_fall && state == bsiu_pkg::TAP_IDLE) |=> !o_test_data_out_oe;
  endproperty
  a_tdoz: assert property (p_tdoz) else $error("data out driven in idle"); // RULE26
endmodule // bsiu_top

/* File: bsiu_pkg.sv */
// Package with constants for the boundary scan instruction unit
package bsiu_pkg;
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLE = 3'h2;
  localparam logic [2:0] IR_CLAMP = 3'h3;
  localparam logic [2:0] IR_HIGHZ = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic ID_LSB = 1'h1;
  localparam int ID_REV_LSB = 28;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  // Arbitrary identity values
  localparam logic [3:0] ID_REV_DEF = 4'h1;
  localparam logic [15:0] ID_DEV_DEF = 16'h1234;
  localparam logic [10:0] ID_MFR_DEF = 11'h055;
  typedef enum logic [3:0] {
    TAP_RESET = 4'hF, TAP_IDLE = 4'hC, TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6,
    TAP_SHIFT_DR = 4'h2, TAP_EXIT1_DR = 4'h1, TAP_PAUSE_DR = 4'h3, TAP_EXIT2_DR = 4'h0,
    TAP_UPD_DR = 4'h5, TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SHIFT_IR = 4'hA,
    TAP_EXIT1_IR = 4'h9, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h8, TAP_UPD_IR = 4'hD
  } bsiu_tap_e;
endpackage

/* File: bsiu_tap_fsm.sv */
// TAP controller state machine
`timescale 1ns/1ps
module bsiu_tap_fsm (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_rise,
  input wire logic i_tms,
  output bsiu_pkg::bsiu_tap_e o_state
);
  bsiu_pkg::bsiu_tap_e next_state;
  always_comb begin
    case (o_state)
      bsiu_pkg::TAP_RESET: next_state = i_tms ? bsiu_pkg::TAP_RESET : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_IDLE: next_state = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_SEL_DR: next_state = i_tms ? bsiu_pkg::TAP_SEL_IR : bsiu_pkg::TAP_CAP_DR;
      bsiu_pkg::TAP_CAP_DR: next_state = i_tms ? bsiu_pkg::TAP_EXIT1_DR : bsiu_pkg::TAP_SHIFT_DR;
      bsiu_pkg::TAP_SHIFT_DR: next_state = i_tms ? bsiu_pkg::TAP_EXIT1_DR : bsiu_pkg::TAP_SHIFT_DR;
      bsiu_pkg::TAP_EXIT1_DR: next_state = i_tms ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_PAUSE_DR;
      bsiu_pkg::TAP_PAUSE_DR: next_state = i_tms ? bsiu_pkg::TAP_EXIT2_DR : bsiu_pkg::TAP_PAUSE_DR;
      bsiu_pkg::TAP_EXIT2_DR: next_state = i_tms ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_SHIFT_DR;
      bsiu_pkg::TAP_UPD_DR: next_state = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      bsiu_pkg::TAP_SEL_IR: next_state = i_tms ? bsiu_pkg::TAP_RESET : bsiu_pkg::TAP_CAP_IR;
      bsiu_pkg::TAP_CAP_IR: next_state = i_tms ? bsiu_pkg::TAP_EXIT1_IR : bsiu_pkg::TAP_SHIFT_IR;
      bsiu_pkg::TAP_SHIFT_IR: next_state = i_tms ? bsiu_pkg::TAP_EXIT1_IR : bsiu_pkg::TAP_SHIFT_IR;
      bsiu_pkg::TAP_EXIT1_IR: next_state = i_tms ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_PAUSE_IR;
      bsiu_pkg::TAP_PAUSE_IR: next_state = i_tms ? bsiu_pkg::TAP_EXIT2_IR : bsiu_pkg::TAP_PAUSE_IR;
      bsiu_pkg::TAP_EXIT2_IR: next_state = i_tms ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_SHIFT_IR;
      bsiu_pkg::TAP_UPD_IR: next_state = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_IDLE;
      default: next_state = bsiu_pkg::TAP_RESET;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_state <= bsiu_pkg::TAP_RESET;
    end else if (i_rise) begin
      o_state <= next_state;
    end
  end
endmodule // bsiu_tap_fsm

/* File: bsiu_jtag_ctl.sv */
// Test controller model that drives the scan pins of the instruction unit
`timescale 1ns/1ps
module bsiu_jtag_ctl (
  input wire logic i_sys_clk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h0;
    o_trst_n = 1'h0;
  end
  // ----------------------------------------
  // One test clock period of 8 system clocks
  // ----------------------------------------
  // Mode-select and data change only while the test clock is low
  task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_sys_clk);
    tdo = i_tdo;
    o_tck <= 1'h1;
    repeat (4) @(posedge i_sys_clk);
    o_tck <= 1'h0;
  endtask
  // Mode-select sequence, lsb first; unused data inverts each period
  task automatic walk(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++) begin
      tck_cycle(seq[i], ~o_tdi, d);
    end
  endtask
  // Instruction scan from idle, back to idle; pause takes the exit2 path
  task automatic ir_load(input logic [2:0] code, input logic pause, output logic [2:0] cap);
    logic d;
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      tck_cycle(i == 2, code[i], d);
      cap[i] = d;
    end
    if (pause) begin
      walk(8'h02, 2);
    end
    walk(8'h01, 2);
    // Let the pin mode set at the last rise reach the pads
    repeat (2) @(posedge i_sys_clk);
  endtask
  // Data scan of n bits from idle, back to idle
  task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = 32'h0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      tck_cycle(i == n - 1, din[i], d);
      dout[i] = d;
    end
    walk(8'h01, 2);
  endtask
  // Five periods with mode-select high
  task automatic tms_reset();
    walk(8'h1F, 5);
    // Let the forced instruction reach the output
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic set_trst(input logic v);
    o_trst_n <= v;
    @(posedge i_sys_clk);
  endtask
endmodule // bsiu_jtag_ctl

/* File: bsiu_top_tb.sv */
// Self-checking bench for the boundary scan instruction unit
`timescale 1ns/1ps
module bsiu_top_tb;
  localparam int N = 8;
  // Arbitrary identity values
  localparam logic [3:0] REV = 4'hA;
  localparam logic [15:0] DEV = 16'h5A3C;
  localparam logic [10:0] MFR = 11'h2B5;
  logic i_sys_clk, i_rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, tdo_line;
  logic [N-1:0] func_out, func_oe, pad_in, pad_out, pad_oe;
  logic [2:0] instr;
  int n_errors, num_checks;
  // Nothing pulls the released data-out line
  assign tdo_line = tdo_oe ? tdo : 1'hZ;
  bsiu_top #(.N_PINS(N), .ID_REV(REV), .ID_DEV(DEV), .ID_MFR(MFR)) dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_test_clock_pin(tck),
    .i_test_mode_select_pin(tms), .i_test_data_in_pin(tdi), .i_test_reset_n_pin(trst_n),
    .i_func_out(func_out), .i_func_oe(func_oe), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_test_data_out_pin(tdo), .o_test_data_out_oe(tdo_oe), .o_instr(instr));
  bsiu_jtag_ctl u_ctl (.i_sys_clk(i_sys_clk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .o_trst_n(trst_n));
  initial begin
    i_sys_clk = 1'h0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_pads(input logic [N-1:0] eo, input logic [N-1:0] ee);
    chk_vec(32'(pad_out), 32'(eo), "pad out");
    chk_vec(32'(pad_oe), 32'(ee), "pad enable");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idcode();
    logic [31:0] q;
    chk_vec(32'(instr), 32'(bsiu_pkg::IR_IDCODE), "instr after reset");
    chk_vec(32'(tdo_oe), 32'h0, "data out idle");
    u_ctl.dr_scan(32, 32'h0, q);
    chk_vec(q, {REV, DEV, MFR, 1'h1}, "id word");
  endtask
  task automatic t_bypass();
    logic [2:0] c;
    logic [31:0] q;
    u_ctl.ir_load(bsiu_pkg::IR_BYPASS, 1'h0, c);
    chk_vec(32'(c[1:0]), 32'h1, "ir capture");
    chk_vec(32'(instr), 32'h7, "bypass latched");
    u_ctl.dr_scan(16, 32'h0000B38D, q);
    chk_vec(q, 32'h0000671A, "bypass delay");
    chk_pads(func_out, func_oe);
  endtask
  task automatic t_codes();
    logic [2:0] c;
    logic [31:0] q;
    for (int k = 0; k < 8; k++) begin
      u_ctl.ir_load(3'(k), k[0], c);
      chk_vec(32'(instr), 32'(k), "code latched");
      if (k >= 3) begin
        u_ctl.dr_scan(2, 32'h3, q);
        chk_vec(q, 32'h2, "bypass selected");
      end
      if (k == 4) begin
        chk_vec(32'(pad_oe), 32'h0, "outputs floated");
      end else if (k != 0 && k != 3) begin
        chk_pads(func_out, func_oe);
      end
    end
  endtask
  task automatic t_extest();
    logic [2:0] c;
    logic [31:0] q;
    u_ctl.ir_load(bsiu_pkg::IR_SAMPLE, 1'h0, c);
    u_ctl.dr_scan(2 * N, 32'h3CFF, q);
    chk_vec(q, {16'h0, pad_in, func_oe}, "sampled pins");
    chk_pads(func_out, func_oe);
    u_ctl.ir_load(bsiu_pkg::IR_EXTEST, 1'h0, c);
    chk_pads(8'h3C, 8'hFF);
    u_ctl.dr_scan(2 * N, 32'hC3FF, q);
    chk_vec(q, {16'h0, pad_in, func_oe}, "extest capture");
    chk_pads(8'hC3, 8'hFF);
    u_ctl.ir_load(bsiu_pkg::IR_CLAMP, 1'h0, c);
    u_ctl.dr_scan(N, 32'h55, q);
    chk_vec(q, 32'hAA, "clamp bypass");
    chk_pads(8'hC3, 8'hFF);
    u_ctl.ir_load(bsiu_pkg::IR_HIGHZ, 1'h0, c);
    u_ctl.ir_load(bsiu_pkg::IR_CLAMP, 1'h0, c);
    chk_pads(8'hC3, 8'hFF);
    u_ctl.ir_load(bsiu_pkg::IR_BYPASS, 1'h0, c);
    chk_pads(func_out, func_oe);
  endtask
  task automatic t_resets();
    logic [2:0] c;
    u_ctl.walk(8'h01, 4);
    chk_vec(32'(tdo_oe), 32'h1, "data out in shift");
    u_ctl.tms_reset();
    chk_vec(32'(instr), 32'(bsiu_pkg::IR_IDCODE), "mode-select reset");
    chk_vec(32'(tdo_oe), 32'h0, "data out released");
    u_ctl.walk(8'h00, 1);
    u_ctl.ir_load(bsiu_pkg::IR_BYPASS, 1'h0, c);
    u_ctl.walk(8'h01, 4);
    u_ctl.set_trst(1'h0);
    u_ctl.set_trst(1'h1);
    repeat (2) @(posedge i_sys_clk);
    chk_vec(32'(instr), 32'(bsiu_pkg::IR_IDCODE), "test reset mid-shift");
    u_ctl.walk(8'h00, 1);
  endtask
  initial begin
    i_rstn = 1'h0;
    func_out = 8'h5A;
    func_oe = 8'h0F;
    pad_in = 8'hA5;
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rstn <= 1'h1;
    u_ctl.set_trst(1'h1);
    u_ctl.walk(8'h00, 1);
    t_idcode();
    t_bypass();
    t_codes();
    t_extest();
    t_resets();
    tally_and_finish();
  end
  initial begin
    #2000000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // bsiu_top_tb
